// [hdl/serial_command_port.sv]
// Serial peripheral slave that frames host register commands for the device core.
`default_nettype none

module serial_command_port #(
  parameter int PROC_QUERY_CYCLES = serial_command_port_pkg::PROC_MAX_CYC  // Query processing time
) (
  input  wire logic                                        clk_sys_i,     // Processor clock, 50 MHz
  input  wire logic                                        rst_n_i,       // Hard reset, active low
  input  wire logic                                        sclk_i,        // Serial clock from host
  input  wire logic                                        cs_n_i,        // Chip select, active low
  input  wire logic                                        mosi_i,        // Serial data from host
  output logic                                             miso_o,        // Serial data to host
  input  wire logic                                        mode_sel_i,    // Edge strap, low = mode 0
  output logic                                             slave_ready_out_o, // High when accepting
  input  wire logic [serial_command_port_pkg::RESULT_W-1:0] query_data_i, // Result from device core
  output logic                                             cmd_valid_o,   // One-cycle command pulse
  output logic [7:0]                                       cmd_addr_o,    // Command register address
  output logic [serial_command_port_pkg::DATA_W-1:0]       cmd_data_o,    // Command value, low aligned
  output logic                                             mode_o         // Latched edge mode
);
  import serial_command_port_pkg::*;

  // ----------------------------------------------------------------------
  // Mode strap
  // ----------------------------------------------------------------------
  logic       mode_s1_reg;
  logic       mode_s2_reg;
  logic [1:0] strap_cnt_reg;
  logic       mode_reg;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_s1_reg <= 1'b1;
      mode_s2_reg <= 1'b1;
    end else begin
      mode_s1_reg <= mode_sel_i;
      mode_s2_reg <= mode_s1_reg;
    end
  end

  // The strap is taken once, after the synchroniser has settled past reset.
  // Its flops reset to the pulled-up level, so the pin is only trusted once
  // a value sampled after the release has reached the second stage.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      strap_cnt_reg <= 2'h0;
    end else if (strap_cnt_reg != STRAP_SETTLE) begin
      strap_cnt_reg <= strap_cnt_reg + 2'h1;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_reg <= 1'b1;
    end else if (strap_cnt_reg == STRAP_SETTLE - 2'h1) begin
      mode_reg <= mode_s2_reg;
    end
  end

  assign mode_o = mode_reg;

  // ----------------------------------------------------------------------
  // Link domain
  // ----------------------------------------------------------------------
  // The mode is static after reset, so inverting the clock is glitch free
  // in operation; mode 1 turns the falling edge into the active one.
  logic link_clk;
  assign link_clk = sclk_i ^ mode_reg;

  logic [2:0] bit_cnt_reg;
  logic [6:0] rx_sh_reg;
  logic [6:0] tx_sh_reg;
  logic       miso_reg;
  logic [7:0] rx_byte_reg;
  logic       rx_tgl_reg;
  logic [7:0] tx_byte_reg;

  // Chip select high clears the bit position, so a frame always starts aligned.
  always_ff @(posedge link_clk or posedge cs_n_i) begin
    if (cs_n_i) begin
      bit_cnt_reg <= 3'h0;
    end else begin
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
    end
  end

  always_ff @(posedge link_clk or posedge cs_n_i) begin
    if (cs_n_i) begin
      rx_sh_reg <= 7'h00;
    end else begin
      rx_sh_reg <= {rx_sh_reg[5:0], mosi_i};
    end
  end

  // The toggle must survive chip select, or the processor would miss a byte.
  // The byte itself stays put until the next eighth edge, which the host
  // spacing between bytes keeps well clear of the processor's read.
  always_ff @(posedge link_clk or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_byte_reg <= 8'h00;
    end else if (bit_cnt_reg == BIT_LAST) begin
      rx_byte_reg <= {rx_sh_reg, mosi_i};
    end
  end

  always_ff @(posedge link_clk or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_tgl_reg <= 1'b0;
    end else if (bit_cnt_reg == BIT_LAST) begin
      rx_tgl_reg <= ~rx_tgl_reg;
    end
  end

  // The transmit byte is held still by the processor between bytes, so the
  // first active edge of a byte may take it without a synchroniser.
  always_ff @(posedge link_clk or posedge cs_n_i) begin
    if (cs_n_i) begin
      miso_reg <= 1'b0;
    end else if (bit_cnt_reg == 3'h0) begin
      miso_reg <= tx_byte_reg[7];
    end else begin
      miso_reg <= tx_sh_reg[6];
    end
  end

  always_ff @(posedge link_clk or posedge cs_n_i) begin
    if (cs_n_i) begin
      tx_sh_reg <= 7'h00;
    end else if (bit_cnt_reg == 3'h0) begin
      tx_sh_reg <= tx_byte_reg[6:0];
    end else begin
      tx_sh_reg <= {tx_sh_reg[5:0], 1'b0};
    end
  end

  assign miso_o = miso_reg;

  // ----------------------------------------------------------------------
  // Byte event crossing
  // ----------------------------------------------------------------------
  logic tgl_s1_reg;
  logic tgl_s2_reg;
  logic tgl_s3_reg;
  logic byte_evt;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tgl_s1_reg <= 1'b0;
      tgl_s2_reg <= 1'b0;
      tgl_s3_reg <= 1'b0;
    end else begin
      tgl_s1_reg <= rx_tgl_reg;
      tgl_s2_reg <= tgl_s1_reg;
      tgl_s3_reg <= tgl_s2_reg;
    end
  end

  assign byte_evt = tgl_s2_reg ^ tgl_s3_reg;

  // ----------------------------------------------------------------------
  // Command framing
  // ----------------------------------------------------------------------
  function automatic logic [2:0] data_len(input logic [7:0] addr);
    unique case (addr)
      ADDR_RF_FREQ:     data_len = LEN_FREQ;
      ADDR_READ_RESULT: data_len = LEN_READ;
      ADDR_LIST_QUERY:  data_len = LEN_LIST;
      default:          data_len = LEN_DEFAULT;
    endcase
  endfunction

  cmd_state_t                 state_reg;
  logic [7:0]                 addr_reg;
  logic [DATA_W-1:0]          data_reg;
  logic [2:0]                 left_reg;
  logic [TIMER_W-1:0]         timer_reg;
  logic                       is_query;
  logic                       is_read;
  logic                       last_byte;
  logic                       busy_done;
  logic                       read_addr_byte;

  assign is_query       = (addr_reg[7:3] == QUERY_GROUP);
  assign is_read        = (addr_reg == ADDR_READ_RESULT);
  // The final data byte of a command closes the frame and starts processing.
  assign last_byte      = (state_reg == ST_DATA) && byte_evt && (left_reg == 3'h1);
  assign busy_done      = (state_reg == ST_BUSY) && (timer_reg == '0);
  assign read_addr_byte = (state_reg == ST_ADDR) && byte_evt && (rx_byte_reg == ADDR_READ_RESULT);

  // A short frame leaves the machine in ST_DATA; the next frame's bytes are taken as the rest of its data.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= ST_ADDR;
    end else begin
      unique case (state_reg)
        ST_ADDR: begin
          if (byte_evt) begin
            state_reg <= ST_DATA;
          end
        end
        ST_DATA: begin
          if (last_byte) begin
            state_reg <= ST_BUSY;
          end
        end
        ST_BUSY: begin
          // Bytes arriving now are dropped on purpose.
          if (busy_done) begin
            state_reg <= ST_ADDR;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      addr_reg <= 8'h00;
    end else if (state_reg == ST_ADDR && byte_evt) begin
      addr_reg <= rx_byte_reg;
    end
  end

  // Data bytes enter at the low end, so the last byte lands in the low bits.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      data_reg <= '0;
    end else if (state_reg == ST_ADDR && byte_evt) begin
      data_reg <= '0;
    end else if (state_reg == ST_DATA && byte_evt) begin
      data_reg <= {data_reg[DATA_W-9:0], rx_byte_reg};
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      left_reg <= 3'h0;
    end else if (state_reg == ST_ADDR && byte_evt) begin
      left_reg <= data_len(rx_byte_reg);
    end else if (state_reg == ST_DATA && byte_evt) begin
      left_reg <= left_reg - 3'h1;
    end
  end

  // Configuration and result reads take the fixed minimum; queries take PROC_QUERY_CYCLES.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      timer_reg <= '0;
    end else if (last_byte) begin
      timer_reg <= is_query ? TIMER_W'(PROC_QUERY_CYCLES - 1)
                            : TIMER_W'(PROC_MIN_CYC - 1);
    end else if (state_reg == ST_BUSY && timer_reg != '0) begin
      timer_reg <= timer_reg - TIMER_W'(1);
    end
  end

  // ----------------------------------------------------------------------
  // Command hand-off and ready
  // ----------------------------------------------------------------------
  logic               cmd_valid_reg;
  logic [7:0]         cmd_addr_reg;
  logic [DATA_W-1:0]  cmd_data_reg;
  logic               ready_reg;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cmd_valid_reg <= 1'b0;
    end else begin
      cmd_valid_reg <= last_byte;
    end
  end

  // The payload is only rewritten with a new command, so the core may read
  // it at leisure until the next pulse.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cmd_addr_reg <= 8'h00;
      cmd_data_reg <= '0;
    end else if (last_byte) begin
      cmd_addr_reg <= addr_reg;
      cmd_data_reg <= {data_reg[DATA_W-9:0], rx_byte_reg};
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ready_reg <= 1'b1;
    end else if (last_byte) begin
      ready_reg <= 1'b0;
    end else if (busy_done) begin
      ready_reg <= 1'b1;
    end
  end

  assign cmd_valid_o       = cmd_valid_reg;
  assign cmd_addr_o        = cmd_addr_reg;
  assign cmd_data_o        = cmd_data_reg;
  assign slave_ready_out_o = ready_reg;

  // ----------------------------------------------------------------------
  // Result buffer and transmit byte
  // ----------------------------------------------------------------------
  logic [RESULT_W-1:0] result_reg;
  logic                pending_reg;

  // Only queries load the buffer; configuration commands leave it alone,
  // so their returned bytes are whatever stands there and carry no meaning.
  // Each byte of a result read moves the next result byte to the front, so
  // it is ready in the transmit register before the host clocks it out.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      result_reg <= '0;
    end else if (busy_done && is_query) begin
      result_reg <= query_data_i;
    end else if (busy_done && is_read) begin
      result_reg <= '0;
    end else if (pending_reg && (read_addr_byte || (state_reg == ST_DATA && byte_evt && is_read))) begin
      result_reg <= {result_reg[RESULT_W-9:0], 8'h00};
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pending_reg <= 1'b0;
    end else if (busy_done && is_query) begin
      pending_reg <= 1'b1;
    end else if (busy_done && is_read) begin
      pending_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_byte_reg <= TX_IDLE;
    end else if (pending_reg) begin
      tx_byte_reg <= result_reg[RESULT_W-1 -: 8];
    end else begin
      tx_byte_reg <= TX_IDLE;
    end
  end

endmodule

`default_nettype wire

// [hdl/serial_command_port_pkg.sv]
// Constants and types shared by the serial command port.
`default_nettype none

package serial_command_port_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_FREQ_MHZ   = 50;
  localparam int PROC_MIN_US    = 50;
  localparam int PROC_MAX_US    = 300;
  localparam int PROC_MIN_CYC   = PROC_MIN_US * CLK_FREQ_MHZ;
  localparam int PROC_MAX_CYC   = PROC_MAX_US * CLK_FREQ_MHZ;
  localparam int TIMER_W        = 16;

  // ----------------------------------------------------------------------
  // Command addresses and lengths
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_RF_FREQ      = 8'h10;
  localparam logic [7:0] ADDR_LIST_QUERY   = 8'h24;
  localparam logic [7:0] ADDR_READ_RESULT  = 8'h37;
  localparam logic [4:0] QUERY_GROUP       = 5'h04;
  localparam logic [2:0] LEN_FREQ          = 3'h7;
  localparam logic [2:0] LEN_READ          = 3'h7;
  localparam logic [2:0] LEN_LIST          = 3'h3;
  localparam logic [2:0] LEN_DEFAULT       = 3'h1;
  localparam int         FRAME_BYTES       = 8;
  localparam int         DATA_W            = 56;
  localparam int         RESULT_W          = FRAME_BYTES * 8;

  // ----------------------------------------------------------------------
  // Reset values and link settings
  // ----------------------------------------------------------------------
  localparam logic [2:0] BIT_LAST          = 3'h7;
  localparam logic [1:0] STRAP_SETTLE      = 2'h3;
  localparam logic [7:0] TX_IDLE           = 8'h00;

  typedef enum logic [1:0] {
    ST_ADDR,
    ST_DATA,
    ST_BUSY
  } cmd_state_t;

endpackage

`default_nettype wire

// [verif/serial_command_port_assertions.sv]
// Concurrent checks on the pins of the serial command port.
`default_nettype none
module serial_command_port_assertions #(
  parameter int PROC_QUERY_CYCLES = 15000  // Query processing time
) (
  input wire logic                                  clk_sys_i,         // Processor clock
  input wire logic                                  rst_n_i,           // Hard reset
  input wire logic                                  cs_n_i,            // Chip select
  input wire logic                                  miso_o,            // Reply data
  input wire logic                                  mode_sel_i,        // Edge strap
  input wire logic                                  slave_ready_out_o, // Ready
  input wire logic                                  cmd_valid_o,       // Command pulse
  input wire logic [7:0]                            cmd_addr_o,        // Command address
  input wire logic [serial_command_port_pkg::DATA_W-1:0] cmd_data_o,   // Command value
  input wire logic                                  mode_o             // Latched mode
);
  import serial_command_port_pkg::*;
  // Slack of a few cycles covers the hand-off between link and core.
  localparam int BUSY_MAX = (PROC_QUERY_CYCLES > PROC_MIN_CYC ? PROC_QUERY_CYCLES : PROC_MIN_CYC) + 8;
  logic [15:0] busy_cnt;
  logic [2:0]  up_cnt;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) busy_cnt <= 16'h0000;
    else busy_cnt <= slave_ready_out_o ? 16'h0000 : busy_cnt + 16'h0001;
  end
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) up_cnt <= 3'h0;
    else up_cnt <= (up_cnt == 3'h7) ? up_cnt : up_cnt + 3'h1;
  end
  sequence s_taken;
    cmd_valid_o && !slave_ready_out_o;
  endsequence
  sequence s_busy_on;
    !cmd_valid_o && !slave_ready_out_o;
  endsequence
  a_valid_pulse: assert property (s_taken |=> s_busy_on)
    else $error("command pulse longer than one cycle");
  a_busy_on_valid: assert property (cmd_valid_o |-> !slave_ready_out_o)
    else $error("ready high at command pulse");
  a_taken_ready: assert property (cmd_valid_o |-> $past(slave_ready_out_o))
    else $error("command taken while busy");
  a_busy_min: assert property ($fell(slave_ready_out_o) |-> !slave_ready_out_o [*8])
    else $error("busy period too short");
  a_busy_bounded: assert property (int'(busy_cnt) < BUSY_MAX)
    else $error("busy period too long");
  a_cmd_held: assert property (!cmd_valid_o |-> $stable(cmd_addr_o) && $stable(cmd_data_o))
    else $error("command outputs changed without pulse");
  a_miso_quiet: assert property (cs_n_i && $past(cs_n_i) |-> !miso_o)
    else $error("reply line active while deselected");
  a_mode_caught: assert property (up_cnt == 3'h3 |-> mode_o == mode_sel_i)
    else $error("mode strap not captured");
  a_mode_fixed: assert property (up_cnt == 3'h7 |-> $stable(mode_o))
    else $error("mode changed after reset");
endmodule
`default_nettype wire

// [verif/serial_command_port_tb_top.sv]
// Self-checking bench for the serial command port.
`default_nettype none
module serial_command_port_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import serial_command_port_pkg::*;
  localparam logic [63:0] RES = 64'h0123_4567_89AB_CDEF;
  logic                clk_sys_i = 1'b0;
  logic                rst_n_i = 1'b0;
  logic                mode_sel_i = 1'b1;
  logic [RESULT_W-1:0] query_data_i = '0;
  logic                sclk, cs_n, mosi, miso, ready, cmd_valid, mode;
  logic [7:0]          cmd_addr;
  logic [DATA_W-1:0]   cmd_data;
  logic [63:0]         rx;
  int                  bad_count = 0;
  int                  tests_run = 0;
  int                  pulses = 0;
  always #10 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) if (cmd_valid === 1'b1) pulses <= pulses + 1;
  spi_host_model host (.mode_i(mode_sel_i), .sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi), .miso_i(miso));
  serial_command_port #(.PROC_QUERY_CYCLES(20)) uut (
    .clk_sys_i, .rst_n_i, .sclk_i(sclk), .cs_n_i(cs_n), .mosi_i(mosi), .miso_o(miso), .mode_sel_i,
    .slave_ready_out_o(ready), .query_data_i, .cmd_valid_o(cmd_valid), .cmd_addr_o(cmd_addr),
    .cmd_data_o(cmd_data), .mode_o(mode));
  task automatic close_out();
    $display("tests_run=%0d bad_count=%0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t %s: got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic wait_ready();
    int k;
    k = 0;
    while (ready !== 1'b1) begin
      @(posedge clk_sys_i);
      k++;
      if (k > 20000) begin
        chk(64'h0, 64'h1, "ready timeout");
        close_out();
      end
    end
  endtask
  task automatic t_reset(input logic m);
    @(posedge clk_sys_i);
    rst_n_i <= 1'b0;
    mode_sel_i <= m;
    repeat (4) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    repeat (8) @(posedge clk_sys_i);
    chk(64'(mode), 64'(m), "mode strap");
    chk(64'(ready), 64'h1, "ready after reset");
    $display("t_reset done");
  endtask
  task automatic t_cmd(input logic [63:0] tx, input int n, input logic [63:0] exp);
    int p;
    p = pulses;
    host.frame(tx, n, rx);
    chk(64'(pulses - p), 64'h1, "one command");
    chk(64'(ready), 64'h0, "busy after command");
    chk({cmd_addr, cmd_data}, exp, "command fields");
    chk(rx, 64'h0, "idle reply");
    wait_ready();
    $display("t_cmd done");
  endtask
  task automatic t_busy();
    host.frame({16'h08_55, 48'h0}, 2, rx);
    host.frame({8'h05, 56'h0}, 1, rx);
    wait_ready();
    host.frame({16'h06_11, 48'h0}, 2, rx);
    chk({cmd_addr, cmd_data}, {8'h06, 48'h0, 8'h11}, "byte ignored while busy");
    wait_ready();
    $display("t_busy done");
  endtask
  task automatic t_query();
    @(posedge clk_sys_i);
    query_data_i <= RES;
    host.frame({32'h24_01_02_03, 32'h0}, 4, rx);
    wait_ready();
    @(posedge clk_sys_i);
    query_data_i <= ~RES;
    host.frame({8'h37, 56'h0}, 8, rx);
    chk(rx, RES, "query result");
    wait_ready();
    host.frame({8'h37, 56'h0}, 8, rx);
    chk(rx, 64'h0, "buffer emptied");
    wait_ready();
    $display("t_query done");
  endtask
  initial begin
    t_reset(1'b1);
    t_cmd({16'h05_AA, 48'h0}, 2, {8'h05, 48'h0, 8'hAA});
    t_cmd(64'h1000_0574_FBDE_6000, 8, 64'h1000_0574_FBDE_6000);
    t_busy();
    t_query();
    t_reset(1'b0);
    t_cmd({16'h07_3C, 48'h0}, 2, {8'h07, 48'h0, 8'h3C});
    close_out();
  end
endmodule
bind serial_command_port serial_command_port_assertions #(.PROC_QUERY_CYCLES(PROC_QUERY_CYCLES)) chk_i (
  .clk_sys_i, .rst_n_i, .cs_n_i, .miso_o, .mode_sel_i, .slave_ready_out_o, .cmd_valid_o, .cmd_addr_o,
  .cmd_data_o, .mode_o);
`default_nettype wire

// [verif/spi_host_model.sv]
// Host model: serial bus master that clocks whole frames into the port.
`default_nettype none
module spi_host_model (
  input  wire logic mode_i, // Edge mode, also the idle clock level
  output logic      sclk_o, // Serial clock
  output logic      cs_n_o, // Chip select
  output logic      mosi_o, // Host data
  input  wire logic miso_i  // Reply data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic ph = 1'b0;
  // The clock stands at its idle level between frames.
  assign sclk_o = mode_i ^ ph;
  initial begin
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end
  task automatic frame(input logic [63:0] tx, input int n, output logic [63:0] rx);
    rx = 64'h0000_0000_0000_0000;
    cs_n_o = 1'b0;
    for (int i = 0; i < 8 * n; i++) begin
      if (i % 8 == 0) #1000;
      mosi_o = tx[63-i];
      #80 ph = 1'b1;
      #80 rx[63-i] = miso_i;
      ph = 1'b0;
    end
    #200 cs_n_o = 1'b1;
    mosi_o = ~mosi_o;
  endtask
endmodule
`default_nettype wire
